// >>> logic/fcm_pkg.sv
// constants, register map and types of the fail-safe clock monitor
package fcm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int AXI_AW   = 32;              // axi address width
  localparam int AXI_DW   = 32;              // axi data width
  localparam logic [1:0] RESP_OKAY   = 2'h0; // normal answer
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address

  ////////////////////////////////////////////////////////////////////////////
  // register indices and byte addresses
  localparam logic [15:0] CFG_WORD1_IDX = 16'h8007;  // configuration word 1 index
  localparam logic [15:0] CFG_WORD2_IDX = 16'h8008;  // configuration word 2 index
  localparam logic [AXI_AW-1:0] ADDR_CFG_WORD1 = {14'h0000, CFG_WORD1_IDX, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_CFG_WORD2 = {14'h0000, CFG_WORD2_IDX, 2'h0};
  localparam logic [AXI_AW-1:0] ADDR_OSC_CTRL  = 32'h00000000; // osc_control_reg
  localparam logic [AXI_AW-1:0] ADDR_IRQ_FLAGS = 32'h00000004; // periph_irq_flags_2
  localparam logic [AXI_AW-1:0] ADDR_IRQ_ENS   = 32'h00000008; // periph_irq_enables_2
  localparam logic [AXI_AW-1:0] ADDR_STATUS    = 32'h0000000c; // monitor status

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int CFG_WIDTH      = 14; // configuration word width
  localparam int CFG_OSC_LSB    = 0;  // cfg_osc_select [2:0]
  localparam int CFG_MON_EN_BIT = 13; // monitor_enable_cfg
  localparam int OSC_SCS_LSB    = 0;  // clock_select_field [1:0]
  localparam int OSC_IFS_LSB    = 3;  // internal_freq_select [6:3]
  localparam int OSC_FAIL_BIT   = 0;  // osc_fail_flag / osc_fail_irq_enable
  localparam int ST_STATE_LSB   = 0;  // status: state code [2:0]
  localparam int ST_OST_BIT     = 3;  // status: start-up timer expired
  localparam int ST_INT_BIT     = 4;  // status: cpu clock on internal source

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CFG_WIDTH-1:0] CFG_WORD1_RST = 14'h3fff; // erased word
  localparam logic [CFG_WIDTH-1:0] CFG_WORD2_RST = 14'h3fff; // erased word
  localparam logic [3:0] IFS_RST = 4'h7;                      // internal freq select
  localparam logic [1:0] SCS_RST = 2'h0;                      // run from config clock

  ////////////////////////////////////////////////////////////////////////////
  // oscillator mode codes of cfg_osc_select and clock_select_field
  localparam logic [2:0] MODE_LOW_POWER_XTAL = 3'h0; // low_power_crystal_mode
  localparam logic [2:0] MODE_STD_XTAL       = 3'h1; // standard_crystal_mode
  localparam logic [2:0] MODE_HIGH_SPEED     = 3'h2; // high_speed_crystal_mode
  localparam logic [2:0] MODE_EXT_RC         = 3'h3; // ext_rc_mode
  localparam logic [2:0] MODE_INTERNAL       = 3'h4; // internal oscillator only
  localparam logic [2:0] MODE_EXT_LOW        = 3'h5; // ext_clock_low_mode
  localparam logic [2:0] MODE_EXT_MEDIUM     = 3'h6; // ext_clock_medium_mode
  localparam logic [2:0] MODE_EXT_HIGH       = 3'h7; // ext_clock_high_mode
  localparam logic [1:0] SCS_CONFIG          = 2'h0; // clock from configuration word
  localparam logic [1:0] SCS_SECONDARY       = 2'h1; // secondary_osc

  ////////////////////////////////////////////////////////////////////////////
  // timing counts
  localparam int FAIL_LF_CYCLES  = 64;   // low-freq ticks without an edge = failure
  localparam int OST_CYCLES      = 1024; // start-up timer length in monitored edges
  localparam int SYNC_STAGES     = 3;    // pin synchroniser depth

  // monitor states
  typedef enum logic [2:0] {
    FCM_RESET,      // first cycle after reset
    FCM_STARTUP,    // start-up timer running, cpu on internal clock
    FCM_RUN_EXT,    // cpu on external clock, monitor watching
    FCM_FAILSAFE,   // failure seen, cpu held on internal clock
    FCM_INTERNAL    // software chose the internal block
  } fcm_state_t;

endpackage

// >>> logic/fcm_pin_sync.sv
// three-stage pin synchroniser with agreed level and falling/rising pulses
`timescale 1ns/1ns
module fcm_pin_sync
(
  input  wire logic ref_clk,  // system clock
  input  wire logic rstn,     // synchronous reset, active low
  input  wire logic pinIn,    // asynchronous pin
  output logic      level,    // filtered level
  output logic      rise,     // one-cycle pulse on agreed rise
  output logic      fall      // one-cycle pulse on agreed fall
);
  import fcm_pkg::*;

  logic [SYNC_STAGES-1:0] stage;       // shift chain, bit 0 first
  logic [SYNC_STAGES-1:0] next_stage;  // next chain value
  logic                   next_level;  // next filtered level

  ////////////////////////////////////////////////////////////////////////////
  // next values: level changes only when stages two and three agree
  always_comb
  begin
    next_stage = {stage[SYNC_STAGES-2:0], pinIn};
    next_level = level;
    if (stage[1] == stage[2])
    begin
      next_level = stage[2];
    end
  end

  // registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      stage <= '0;
      level <= 1'b0;
    end
    else
    begin
      stage <= next_stage;
      level <= next_level;
    end
  end

  // edge pulses from the agreed level
  assign rise = next_level & ~level;
  assign fall = ~next_level & level;

endmodule

// >>> logic/fcm_monitor.sv
// fail-safe clock monitor with axi4-lite register access
//
// Contract
// RQ1: config words at indices 8007h and 8008h
// RQ2: monitor works only when enable bit set
// RQ3: covers crystal, external clock, secondary modes
// RQ4: crystal needs timer expiry; external clock immediate
// RQ5: falling edges timed by low-freq oscillator
// RQ6: failure moves cpu internal, sets flag
// RQ7: internal source from frequency select field
// RQ8: interrupt when flag and enable set
// RQ9: stay internal until condition cleared
// RQ10: software clears crystal failure by sequence
// RQ11: select internal block resets start-up timer
// RQ12: software clears the fail flag
// RQ13: select config clock restarts start-up timer
// RQ14: timer expiry returns to external, clears
// RQ15: persisting failure sets flag again
// RQ16: external clock failure cleared by software
// RQ17: external clock returns without start-up delay
// RQ18: counter restarts per edge, fails at limit
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module fcm_monitor
#(
  parameter int FAIL_TICKS = fcm_pkg::FAIL_LF_CYCLES,  // failure limit in low-freq ticks
  parameter int OST_EDGES  = fcm_pkg::OST_CYCLES       // start-up timer length
)
(
  input  wire logic                       ref_clk,        // system clock
  input  wire logic                       rstn,           // synchronous reset, active low
  input  wire logic                       extClkPin,      // monitored external clock
  input  wire logic                       lowFreqOscPin,  // low_freq_internal_osc time base
  input  wire logic [fcm_pkg::AXI_AW-1:0] s_axi_awaddr,   // write address
  input  wire logic                       s_axi_awvalid,  // write address valid
  output logic                            s_axi_awready,  // write address ready
  input  wire logic [fcm_pkg::AXI_DW-1:0] s_axi_wdata,    // write data
  input  wire logic [3:0]                 s_axi_wstrb,    // write byte lanes
  input  wire logic                       s_axi_wvalid,   // write data valid
  output logic                            s_axi_wready,   // write data ready
  output logic [1:0]                      s_axi_bresp,    // write response
  output logic                            s_axi_bvalid,   // write response valid
  input  wire logic                       s_axi_bready,   // write response ready
  input  wire logic [fcm_pkg::AXI_AW-1:0] s_axi_araddr,   // read address
  input  wire logic                       s_axi_arvalid,  // read address valid
  output logic                            s_axi_arready,  // read address ready
  output logic [fcm_pkg::AXI_DW-1:0]      s_axi_rdata,    // read data
  output logic [1:0]                      s_axi_rresp,    // read response
  output logic                            s_axi_rvalid,   // read data valid
  input  wire logic                       s_axi_rready,   // read data ready
  output logic                            cpuClkInternal, // 1: cpu runs on internal clock
  output logic [3:0]                      intFreqSel,     // chosen internal source
  output logic                            oscFailIrq      // level interrupt
);
  import fcm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                 extLevel;      // synchronised external clock
  logic                 extFall;       // falling edge of external clock
  logic                 lfRise;        // low-freq tick
  logic [CFG_WIDTH-1:0] cfgWord1;      // configuration word 1
  logic [CFG_WIDTH-1:0] cfgWord2;      // configuration word 2
  logic [1:0]           clockSelect;   // clock_select_field
  logic [3:0]           freqSelect;    // internal_freq_select
  logic                 oscFailFlag;   // osc_fail_flag, sticky
  logic                 oscFailEn;     // osc_fail_irq_enable
  logic                 bValid;        // write answer pending
  logic [1:0]           bResp;         // write answer code
  logic                 rValid;        // read answer pending
  logic [1:0]           rResp;         // read answer code
  logic [AXI_DW-1:0]    rData;         // read answer data
  logic [CFG_WIDTH-1:0] next_cfgWord1, next_cfgWord2;
  logic [1:0]           next_clockSelect;
  logic [3:0]           next_freqSelect;
  logic                 next_oscFailFlag, next_oscFailEn;
  logic                 next_bValid, next_rValid;
  logic [1:0]           next_bResp, next_rResp;
  logic [AXI_DW-1:0]    next_rData;
  logic                 wrFire;        // write taken this cycle
  logic                 rdFire;        // read taken this cycle
  logic                 failEvent;     // hardware sets the fail flag
  fcm_state_t           state, next_state;
  logic [15:0]          lfCount, next_lfCount;   // ticks since last edge
  logic [15:0]          ostCount, next_ostCount; // start-up edges counted
  logic                 ostDone, next_ostDone;   // start-up timer expired
  logic                 failSeen;      // counter at its limit
  logic                 retrying;      // start-up after a failure
  logic                 next_retrying;
  logic [2:0]           oscMode;       // cfg_osc_select
  logic                 monitorEn;     // monitor_enable_cfg
  logic                 needsOst;      // source is a crystal

  // merge a write into a register under byte lanes
  function automatic logic [AXI_DW-1:0] merge(input logic [AXI_DW-1:0] old,
                                               input logic [AXI_DW-1:0] data,
                                               input logic [3:0]        strb);
    logic [AXI_DW-1:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // true for the crystal-type sources that need the start-up timer
  function automatic logic isCrystal(input logic [2:0] mode, input logic [1:0] clock_select_field);
    return (clock_select_field == SCS_SECONDARY) || (mode == MODE_LOW_POWER_XTAL) ||
           (mode == MODE_STD_XTAL) || (mode == MODE_HIGH_SPEED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  fcm_pin_sync u_extSync
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (extClkPin),
    .level   (extLevel),
    .rise    (),
    .fall    (extFall)
  );

  fcm_pin_sync u_lfSync
  (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .pinIn   (lowFreqOscPin),
    .level   (),
    .rise    (lfRise),
    .fall    ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes: address and data taken together, one answer at a time
  assign wrFire        = s_axi_awvalid & s_axi_wvalid & ~bValid;
  assign rdFire        = s_axi_arvalid & ~rValid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready  = wrFire;
  assign s_axi_arready = ~rValid;
  assign s_axi_bvalid  = bValid;
  assign s_axi_bresp   = bResp;
  assign s_axi_rvalid  = rValid;
  assign s_axi_rresp   = rResp;
  assign s_axi_rdata   = rData;

  assign oscMode   = cfgWord1[CFG_OSC_LSB +: 3];
  assign monitorEn = cfgWord1[CFG_MON_EN_BIT];
  assign needsOst  = isCrystal(oscMode, clockSelect);                  // [RQ3] [RQ4]

  ////////////////////////////////////////////////////////////////////////////
  // register file next values
  always_comb
  begin
    logic [AXI_DW-1:0] wv;
    wv               = '0;
    next_cfgWord1    = cfgWord1;
    next_cfgWord2    = cfgWord2;
    next_clockSelect = clockSelect;
    next_freqSelect  = freqSelect;
    next_oscFailFlag = oscFailFlag;
    next_oscFailEn   = oscFailEn;
    next_bValid      = bValid & ~s_axi_bready;
    next_bResp       = bResp;
    next_rValid      = rValid & ~s_axi_rready;
    next_rResp       = rResp;
    next_rData       = rData;
    // writes
    if (wrFire)
    begin
      next_bValid = 1'b1;
      next_bResp  = RESP_OKAY;
      unique case (s_axi_awaddr)
        ADDR_CFG_WORD1:                                                 // [RQ1]
        begin
          wv            = merge({18'h00000, cfgWord1}, s_axi_wdata, s_axi_wstrb);
          next_cfgWord1 = wv[CFG_WIDTH-1:0];
        end
        ADDR_CFG_WORD2:                                                 // [RQ1]
        begin
          wv            = merge({18'h00000, cfgWord2}, s_axi_wdata, s_axi_wstrb);
          next_cfgWord2 = wv[CFG_WIDTH-1:0];
        end
        ADDR_OSC_CTRL:
        begin
          wv = merge({25'h0000000, freqSelect, 1'b0, clockSelect}, s_axi_wdata,
                     s_axi_wstrb);
          next_clockSelect = wv[OSC_SCS_LSB +: 2];
          next_freqSelect  = wv[OSC_IFS_LSB +: 4];                      // [RQ7]
        end
        ADDR_IRQ_FLAGS:
        begin
          // write one clears
          if (s_axi_wstrb[0] && s_axi_wdata[OSC_FAIL_BIT])
          begin
            next_oscFailFlag = 1'b0;                                    // [RQ12] [RQ16]
          end
        end
        ADDR_IRQ_ENS:
        begin
          if (s_axi_wstrb[0])
          begin
            next_oscFailEn = s_axi_wdata[OSC_FAIL_BIT];
          end
        end
        ADDR_STATUS: ;                                                  // read only
        default: next_bResp = RESP_SLVERR;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    if (failEvent)
    begin
      next_oscFailFlag = 1'b1;                                          // [RQ6] [RQ15]
    end
    // reads
    if (rdFire)
    begin
      next_rValid = 1'b1;
      next_rResp  = RESP_OKAY;
      next_rData  = '0;
      unique case (s_axi_araddr)
        ADDR_CFG_WORD1: next_rData = {18'h00000, cfgWord1};
        ADDR_CFG_WORD2: next_rData = {18'h00000, cfgWord2};
        ADDR_OSC_CTRL:  next_rData = {25'h0000000, freqSelect, 1'b0, clockSelect};
        ADDR_IRQ_FLAGS: next_rData = {31'h00000000, oscFailFlag};
        ADDR_IRQ_ENS:   next_rData = {31'h00000000, oscFailEn};
        ADDR_STATUS:
        begin
          next_rData[ST_STATE_LSB +: 3] = state;
          next_rData[ST_OST_BIT]        = ostDone;
          next_rData[ST_INT_BIT]        = cpuClkInternal;
        end
        default: next_rResp = RESP_SLVERR;
      endcase
    end
  end

  // register file flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cfgWord1    <= CFG_WORD1_RST;
      cfgWord2    <= CFG_WORD2_RST;
      clockSelect <= SCS_RST;
      freqSelect  <= IFS_RST;
      oscFailFlag <= 1'b0;
      oscFailEn   <= 1'b0;
      bValid      <= 1'b0;
      bResp       <= RESP_OKAY;
      rValid      <= 1'b0;
      rResp       <= RESP_OKAY;
      rData       <= '0;
    end
    else
    begin
      cfgWord1    <= next_cfgWord1;
      cfgWord2    <= next_cfgWord2;
      clockSelect <= next_clockSelect;
      freqSelect  <= next_freqSelect;
      oscFailFlag <= next_oscFailFlag;
      oscFailEn   <= next_oscFailEn;
      bValid      <= next_bValid;
      bResp       <= next_bResp;
      rValid      <= next_rValid;
      rResp       <= next_rResp;
      rData       <= next_rData;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // monitor state machine and counters
  assign failSeen = (lfCount >= 16'(FAIL_TICKS));                       // [RQ18]

  always_comb
  begin
    next_state    = state;
    next_lfCount  = lfCount;
    next_ostCount = ostCount;
    next_ostDone  = ostDone;
    next_retrying = retrying;
    failEvent     = 1'b0;
    // edge watchdog: restart on each falling edge, count low-freq ticks
    if (extFall)
    begin
      next_lfCount = '0;                                                // [RQ5] [RQ18]
    end
    else if (lfRise && !failSeen)
    begin
      next_lfCount = lfCount + 16'h0001;                                // [RQ5]
    end
    unique case (state)
      FCM_RESET:
      begin
        next_ostCount = '0;
        next_ostDone  = 1'b0;
        next_lfCount  = '0;
        if (clockSelect[1])
          next_state = FCM_INTERNAL;
        else if (needsOst || oscMode == MODE_INTERNAL)
          next_state = FCM_STARTUP;                                     // [RQ4]
        else
          next_state = FCM_RUN_EXT;                                     // [RQ4]
      end
      FCM_STARTUP:
      begin
        if (clockSelect[1])
        begin
          next_state    = FCM_INTERNAL;                                 // [RQ11]
          next_ostCount = '0;                                           // [RQ11]
        end
        else if (ostCount >= 16'(OST_EDGES) || !needsOst)
        begin
          next_state    = FCM_RUN_EXT;                                  // [RQ14]
          next_ostDone  = 1'b1;
          next_retrying = 1'b0;                                         // [RQ14]
          next_lfCount  = '0;
        end
        else if (retrying && monitorEn && failSeen)
        begin
          next_state = FCM_FAILSAFE;                                    // [RQ15]
          failEvent  = 1'b1;                                            // [RQ15]
        end
        else if (extFall)
        begin
          next_ostCount = ostCount + 16'h0001;                          // [RQ13]
        end
      end
      FCM_RUN_EXT:
      begin
        if (clockSelect[1])
          next_state = FCM_INTERNAL;
        else if (monitorEn && oscMode != MODE_INTERNAL && failSeen)     // [RQ2] [RQ3]
        begin
          next_state    = FCM_FAILSAFE;                                 // [RQ6]
          failEvent     = 1'b1;                                         // [RQ6]
          next_retrying = 1'b1;
        end
      end
      FCM_FAILSAFE:
      begin
        // held on internal clock until software picks the internal block
        if (clockSelect[1])
        begin
          next_state    = FCM_INTERNAL;                                 // [RQ9] [RQ11]
          next_ostCount = '0;                                           // [RQ11]
          next_ostDone  = 1'b0;
        end
      end
      FCM_INTERNAL:
      begin
        next_ostCount = '0;                                             // [RQ11]
        next_ostDone  = 1'b0;
        if (!clockSelect[1])
        begin
          next_lfCount = '0;
          if (needsOst)
            next_state = FCM_STARTUP;                                   // [RQ13]
          else
          begin
            next_state    = FCM_RUN_EXT;                                // [RQ17]
            next_ostDone  = 1'b1;
            next_retrying = 1'b0;
          end
        end
      end
    endcase
  end

  // monitor flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state    <= FCM_RESET;
      lfCount  <= '0;
      ostCount <= '0;
      ostDone  <= 1'b0;
      retrying <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      lfCount  <= next_lfCount;
      ostCount <= next_ostCount;
      ostDone  <= next_ostDone;
      retrying <= next_retrying;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs: cpu on internal clock everywhere except healthy external run
  assign cpuClkInternal = (state != FCM_RUN_EXT) || (oscMode == MODE_INTERNAL); // [RQ6] [RQ9]
  assign intFreqSel     = freqSelect;                                   // [RQ7]
  assign oscFailIrq     = oscFailFlag & oscFailEn;                      // [RQ8]

endmodule

// >>> verif/fcm_monitor_assertions.sv
// bound checker for the monitor's bus handshake and fail-safe outputs
`timescale 1ns/1ns
module fcm_monitor_assertions
  import fcm_pkg::*;
(
  input wire logic              ref_clk,        // clock
  input wire logic              rstn,           // reset, active low
  input wire logic              s_axi_awvalid,  // aw valid
  input wire logic              s_axi_wvalid,   // w valid
  input wire logic              s_axi_awready,  // aw ready
  input wire logic              s_axi_bvalid,   // b valid
  input wire logic              s_axi_bready,   // b ready
  input wire logic [1:0]        s_axi_bresp,    // b response
  input wire logic              s_axi_arvalid,  // ar valid
  input wire logic              s_axi_rvalid,   // r valid
  input wire logic              s_axi_rready,   // r ready
  input wire logic [AXI_DW-1:0] s_axi_rdata,    // r data
  input wire logic              cpuClkInternal, // cpu on internal source
  input wire logic [3:0]        intFreqSel,     // internal source select
  input wire logic              oscFailIrq      // level interrupt
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // a write is taken when both halves are offered and no answer waits
  sequence wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  endsequence
  wr_answer_a: assert property (wr_take |=> s_axi_bvalid) else $error("write not answered");
  rd_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read not answered");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  // failure raises the interrupt together with the move to the internal clock
  fail_switch_a: assert property ($rose(oscFailIrq) && !s_axi_bvalid |-> cpuClkInternal)
    else $error("interrupt without internal clock");
  irq_fall_a: assert property ($fell(oscFailIrq) |-> s_axi_bvalid)
    else $error("interrupt fell without a write");
  ifs_write_a: assert property ($changed(intFreqSel) |-> s_axi_bvalid)
    else $error("source select changed without a write");
  reset_vals_a: assert property ($rose(rstn) |-> intFreqSel == IFS_RST && !oscFailIrq)
    else $error("wrong values out of reset");
endmodule
bind fcm_monitor fcm_monitor_assertions fcm_monitor_assertions_inst (.*);

// >>> verif/fcm_ext_osc_model.sv
// external oscillator model that can fail by freezing its output
`timescale 1ns/1ns
module fcm_ext_osc_model
#(
  parameter int HALF_NS = 30 // half period while running
)
(
  input  wire logic run,   // 1: oscillate, 0: failed
  output logic      clkOut // monitored clock pin
);
  // a failed oscillator stands still, so no falling edge reaches the monitor
  initial
  begin
    clkOut = 1'b0;
    forever
    begin
      #HALF_NS;
      if (run)
        clkOut = ~clkOut;
    end
  end
endmodule

// >>> verif/fail_safe_clock_monitor_tb.sv
// bench: registers, failure detection, clearing and disable of the monitor
`timescale 1ns/1ns
module fail_safe_clock_monitor_tb;
  import fcm_pkg::*;
  localparam int TK = 20; // ref cycles per low-freq tick
  logic ref_clk = 1'b0, rstn = 1'b0, lowFreqOscPin = 1'b0, extRun = 1'b1, extClkPin;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_awready;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_rvalid, s_axi_arready;
  logic s_axi_wready, s_axi_bvalid, cpuClkInternal, oscFailIrq;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, intFreqSel, ifs;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int failCount = 0, cmpCount = 0, c, expFlag = 0, expEn = 0;
  int modes[$] = '{0, 1, 2, 3, 5, 6, 7}; // monitored oscillator modes
  fcm_monitor #(.FAIL_TICKS(4), .OST_EDGES(8)) fcm_monitor_inst (.*);
  fcm_ext_osc_model #(.HALF_NS(30)) fcm_ext_osc_model_inst (.run(extRun), .clkOut(extClkPin));
  initial forever #5 ref_clk = ~ref_clk;
  initial forever #(TK*5) lowFreqOscPin = ~lowFreqOscPin;
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // axi write: both halves held until taken; bready comes a cycle late
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    @(posedge ref_clk);
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // bounded wait for cpu select (sel 1) or interrupt (sel 0) to reach v
  task automatic waitFor(input int sel, input logic v);
    c = 0;
    while (((sel != 0) ? cpuClkInternal : oscFailIrq) !== v && c < 2000)
    begin
      @(posedge ref_clk);
      c++;
    end
  endtask
  task automatic stopClk(input logic det);
    extRun <= 1'b0;
    waitFor(0, 1'b1);
    if (det)
      expFlag = 1;
    check(oscFailIrq, expFlag & expEn);
    check(cpuClkInternal, det);
    if (det)
      check(c inside {[2*TK-6:6*TK+8]}, 1);
  endtask
  // software clearing: internal block, flag clear, back to configured clock
  task automatic clearSeq(input logic alive, input logic xtal);
    wr(ADDR_OSC_CTRL, {25'h0, ifs, 3'h2});
    wr(ADDR_IRQ_FLAGS, 32'h1);
    expFlag = 0;
    check(oscFailIrq, 1'b0);
    extRun <= alive;
    wr(ADDR_OSC_CTRL, {25'h0, ifs, 3'h0});
    waitFor(alive, !alive);
    expFlag = !alive;
    check(cpuClkInternal, !alive);
    check(oscFailIrq, expFlag & expEn);
    if (alive)
      check(xtal ? c >= 7 * 6 : c <= 6, 1);
  endtask
  task automatic finalReport();
    if (failCount == 0 && cmpCount > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    failCount++;
    finalReport();
  end
  initial
  begin
    void'($urandom(68));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    check(intFreqSel, IFS_RST);
    rd(ADDR_CFG_WORD1, 32'h3fff, RESP_OKAY);
    rd(ADDR_CFG_WORD2, 32'h3fff, RESP_OKAY);
    rd(32'h10, 32'h0, RESP_SLVERR);
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    wr(32'h10, 32'h0);
    check(s_axi_bresp, RESP_SLVERR);
    ifs = 4'($urandom_range(15));
    wr(ADDR_IRQ_ENS, 32'h1);
    expEn = 1;
    foreach (modes[i])
    begin
      wr(ADDR_CFG_WORD1, 32'h2000 | modes[i]);
      wr(ADDR_OSC_CTRL, {25'h0, ifs, 3'h0});
      check(intFreqSel, ifs);
      waitFor(1, 1'b0);
      check(cpuClkInternal, 1'b0);
      stopClk(1'b1);
      rd(ADDR_IRQ_FLAGS, 32'h1, RESP_OKAY);
      clearSeq(1'b1, modes[i] < 3);
    end
    stopClk(1'b1);
    clearSeq(1'b0, 1'b0);
    wr(ADDR_IRQ_ENS, 32'h0);
    expEn = 0;
    check(oscFailIrq, 1'b0);
    wr(ADDR_IRQ_ENS, 32'h1);
    expEn = 1;
    check(oscFailIrq, 1'b1);
    clearSeq(1'b1, 1'b0);
    wr(ADDR_CFG_WORD1, 32'h0007);
    stopClk(1'b0);
    finalReport();
  end
endmodule
